// *** bench/audio_source.sv ***
// Purpose: Serial audio source model driving the receiver's audio pins
// Assumes: One push per frame; bit clock stands low between pushes
// Notes: Each push finishes the frame queued by the push before it
`timescale 1ns/1ps
module audio_source
(
  // Serial audio pins
  output logic o_bclk,
  output logic o_lrclk,
  output logic o_data
);
  logic [1:0] pf;
  int pn;
  logic [23:0] pl;
  logic [23:0] pr;
  bit pend;

  initial
  begin
    o_bclk = 1'b0;
    o_lrclk = 1'b0;
    o_data = 1'b0;
    pend = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit of a slot: RJ ends on the LSB, I2S lags one bit behind LJ
  function automatic logic bit_at(logic [1:0] f, int n, logic [23:0] w,
    int p);
    if (f == 2'h1)
      return (p >= n - 24) ? w[n - 1 - p] : 1'b0;
    if (f != 2'h2)
      p = p - 1;
    return (p >= 0 && p < 24) ? w[23 - p] : 1'b0;
  endfunction

  // Data moves on the fall, so it is steady at the sampling rise
  task automatic emit(logic lr, logic d);
    o_bclk = 1'b0;
    o_lrclk = lr;
    o_data = d;
    #40;
    o_bclk = 1'b1;
    #40;
  endtask

  task automatic push(logic [1:0] f, int n, logic [23:0] l, logic [23:0] r);
    logic hi;
    logic d0;
    hi = (pf == 2'h1 || pf == 2'h2);
    #17;
    if (pend)
      // I2S left LSB falls on the first bit of the right slot
      for (int k = 1; k < 2 * pn; k++)
        emit((k < pn) ? hi : ~hi, (!hi && k == pn) ? bit_at(pf, pn, pl, pn)
          : bit_at(pf, pn, (k < pn) ? pl : pr, k % pn));
    hi = (f == 2'h1 || f == 2'h2);
    d0 = hi ? bit_at(f, n, l, 0) : (pend ? bit_at(2'h2, pn, pr, pn - 1) : 0);
    // Word clock change at this rise closes the queued frame
    emit(hi, d0);
    o_bclk = 1'b0;
    o_data = ~d0;
    pf = f;
    pn = n;
    pl = l;
    pr = r;
    pend = 1'b1;
  endtask
endmodule

// *** bench/tb.sv ***
// Purpose: Self-checking bench of the audio input and control target
// Assumes: Bus driven slowly, 8 system clocks low and 9 high per bus clock
// Notes: Checked frames are those completed after a format settles
`timescale 1ns/1ps
module tb;
  import adly_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl = 1'b1;
  logic m_sda = 1'b1;
  logic [2:0] sel = 3'h0;
  logic bclk, lrclk, adata, sda_o, sda_oe, valid;
  logic [1:0] fmt, mute;
  logic [23:0] left, right, el, er;
  logic [7:0] v, rb;
  logic [1:0] a;
  wire sda = m_sda & (sda_oe ? sda_o : 1'b1);
  int err_count = 0;
  int samples_checked = 0;
  int seed;
  int cyc = 0;

  audio_delay_input dut_u (.I_CLK(clk), .I_RST(rst), .I_BCLK(bclk),
    .I_LRCLK(lrclk), .I_DATA(adata), .I_SCL(scl), .I_SDA(sda),
    .O_SDA(sda_o), .O_SDA_OE(sda_oe), .I_ADDR_SELECT_BIT0(sel[0]),
    .I_ADDR_SELECT_BIT1(sel[1]), .I_ADDR_SELECT_BIT2(sel[2]),
    .O_LEFT(left), .O_RIGHT(right), .O_SAMPLE_VALID(valid),
    .O_FORMAT(fmt), .O_MUTE(mute));
  audio_source src_u (.o_bclk(bclk), .o_lrclk(lrclk), .o_data(adata));

  always #20 clk = ~clk;

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic hold(int n);
    repeat (n) @(posedge clk);
  endtask

  // One bus clock; the line is sampled early and late in the high phase
  task automatic bit_out(logic b, output logic s1, output logic s2);
    m_sda <= b;
    hold(4);
    scl <= 1'b1;
    hold(1);
    @(negedge clk) s1 = sda;
    hold(7);
    @(negedge clk) s2 = sda;
    hold(1);
    scl <= 1'b0;
    hold(4);
  endtask

  task automatic xfer(logic [7:0] wb, logic mack, output logic [7:0] r,
    output logic [1:0] ack);
    logic s1;
    for (int i = 7; i >= 0; i--)
      bit_out(wb[i], s1, r[i]);
    bit_out(mack, ack[1], ack[0]);
  endtask

  task automatic wb(logic [7:0] b, logic [1:0] e);
    xfer(b, 1'b1, rb, a);
    check("ack", 24'(a), 24'(e));
  endtask

  task automatic start();
    m_sda <= 1'b1;
    hold(8);
    scl <= 1'b1;
    hold(8);
    m_sda <= 1'b0;
    hold(8);
    scl <= 1'b0;
    hold(4);
  endtask

  task automatic stop();
    m_sda <= 1'b0;
    hold(8);
    scl <= 1'b1;
    hold(8);
    m_sda <= 1'b1;
    hold(8);
  endtask

  // Dummy byte to 0x00 first, so the value lands only if the pointer moves
  task automatic set_ctrl(logic [2:0] s, logic [7:0] val);
    sel <= s;
    hold(4);
    start();
    wb({ADDR_FIXED, s, 1'b0}, 2'b00);
    wb(8'h00, 2'b00);
    wb(8'h5a, 2'b00);
    wb(val, 2'b00);
    stop();
    hold(4);
    check("format", 24'(fmt), 24'(val[1:0]));
    check("mute", 24'(mute), 24'(val[7:6]));
  endtask

  function automatic logic [23:0] exp_word(logic [1:0] f, int n,
    logic [23:0] w);
    if (f == FMT_RJ || n >= 24)
      return w;
    return w & (24'hffffff << (24 - n));
  endfunction

  task automatic frame(logic [1:0] f, int i);
    logic [23:0] l, r;
    logic seen;
    int n, base;
    base = (f == FMT_RJ) ? 24 : 16;
    n = base + int'((32'($random(seed)) & 32'h7fffffff) %
      ((f == FMT_RJ) ? 9 : 17));
    n = (i == 2) ? 32 : (i == 3) ? base : n;
    l = 24'($random(seed));
    r = 24'($random(seed));
    src_u.push(f, n, l, r);
    seen = 1'b0;
    for (int t = 0; t < 20 && seen !== 1'b1; t++)
      @(negedge clk) seen = valid;
    if (i > 1)
    begin
      check("valid", 24'(seen), 24'h1);
      check("left", left, el);
      check("right", right, er);
    end
    el = exp_word(f, n, l);
    er = exp_word(f, n, r);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 95;
    fork
      hold(5);
      begin
        src_u.emit(1'b0, 1'b0);
        src_u.emit(1'b0, 1'b0);
      end
    join
    rst <= 1'b0;
    hold(4);
    check("reset oe", 24'(sda_oe), 24'h0);
    check("reset format", 24'(fmt), 24'(CTRL_RESET[1:0]));
    for (int f = 0; f < 4; f++)
    begin
      set_ctrl(3'(f + 3), {2'(f), 4'h0, 2'(f)});
      for (int i = 0; i < 6; i++)
        frame(2'(f), i);
    end
    for (int s = 0; s < 8; s++)
    begin
      v = 8'($random(seed));
      set_ctrl(3'(s), v);
      start();
      wb({ADDR_FIXED, 3'(s) ^ 3'h1, 1'b0}, 2'b11);
      wb(8'h01, 2'b11);
      wb(~v, 2'b11);
      stop();
      start();
      wb({4'h5, 3'(s), 1'b0}, 2'b11);
      stop();
      check("kept format", 24'(fmt), 24'(v[1:0]));
    end
    start();
    wb({ADDR_FIXED, sel, 1'b0}, 2'b00);
    wb(CTRL_REG_ADDR, 2'b00);
    start();
    wb({ADDR_FIXED, sel, 1'b1}, 2'b00);
    xfer(8'hff, 1'b0, rb, a);
    check("read ctrl", 24'(rb), 24'(v));
    xfer(8'hff, 1'b1, rb, a);
    check("read next", 24'(rb), 24'(UNMAPPED_READ));
    stop();
    test_done();
  end
endmodule

// *** hdl/adly_pkg.sv ***
// Purpose: Shared constants and types of the delay input block
// Assumes: Control register map holds only the control byte here
// Notes: Delay and packet-length registers live elsewhere
package adly_pkg;

  localparam int SAMPLE_W = 24;

  // Control bus register map
  localparam logic [7:0] CTRL_REG_ADDR = 8'h01;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int FMT_LSB = 0;
  localparam int MUTE_LSB = 6;

  // Fixed upper nibble of the 7-bit target address
  localparam logic [3:0] ADDR_FIXED = 4'hd;

  // Framing selections
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_RJ = 2'h1;
  localparam logic [1:0] FMT_LJ = 2'h2;
  localparam logic [1:0] FMT_BYPASS = 2'h3;

  // Synchronised pin vector: {sel2, sel1, sel0, sda, scl}
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_SEL = 2;
  localparam logic [4:0] PINS_IDLE = 5'h03;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_REG = 3'b010,
    ST_WDATA = 3'b011,
    ST_ACK = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK = 3'b110,
    ST_IGNORE = 3'b111
  } bus_state_t;

endpackage

// *** hdl/audio_delay_input.sv ***
// Purpose: Serial audio input and two-wire control target of the delay
// Assumes: I_CLK far faster than the bus clock; bit clock under I_CLK/2
// Notes: Only the control byte is stored; other offsets read as zero
// Operation
// - Sample audio data on bit clock rise.
// - Word clock edges move words into channels.
// - Work with 32 to 64 bits per frame. Right justified here takes the last 24 bits, so it needs 48 or more.
// - Audio timing derives from the bit clock only.
// - I2S, left and right justified, bus selected.
// - I2S: low word clock means left.
// - Justified formats: high word clock means left.
// - Bus bytes are eight bits, MSB first, acknowledged.
// - Start and stop seen while clock high.
// - Data line changes only while clock low.
// - Acknowledge holds data low whole clock period.
// - Address is 1101 plus three select pins.
// - Any number of bytes per transaction.
// - Control byte bits 1:0 select the format.
// - First byte points; data writes then advance.
// - Direction bit zero writes, one reads.
`timescale 1ns/1ps
module audio_delay_input
  import adly_pkg::*;
(
  // System clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Serial audio link
  input wire logic I_BCLK,
  input wire logic I_LRCLK,
  input wire logic I_DATA,
  // Two-wire control bus
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // Address select pins
  input wire logic I_ADDR_SELECT_BIT0,
  input wire logic I_ADDR_SELECT_BIT1,
  input wire logic I_ADDR_SELECT_BIT2,
  // Received audio
  output logic [SAMPLE_W-1:0] O_LEFT,
  output logic [SAMPLE_W-1:0] O_RIGHT,
  output logic O_SAMPLE_VALID,
  // Configuration in force
  output logic [1:0] O_FORMAT,
  output logic [1:0] O_MUTE
);

  typedef struct packed {
    logic [4:0] p1;
    logic [4:0] p2;
    logic [4:0] p3;
    logic [4:0] pf;
    bus_state_t state;
    bus_state_t ack_next;
    logic [2:0] cnt;
    logic got;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic [7:0] ctrl;
    logic sda_out;
    logic sda_oe;
    logic t1;
    logic t2;
    logic t3;
    logic tf;
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
    logic valid;
  } bus_t;

  bus_t st;
  bus_t next_st;
  logic [4:0] pins;
  logic [4:0] nf;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic match;
  logic ntf;
  logic [7:0] rd_next;

  rx_link_if link ();

  serial_audio_rx u_rx (
    .i_bclk(I_BCLK),
    .i_rst(I_RST),
    .i_lrclk(I_LRCLK),
    .i_data(I_DATA),
    .link(link.rx)
  );

  assign link.fmt = st.ctrl[FMT_LSB +: 2];
  assign pins = {I_ADDR_SELECT_BIT2, I_ADDR_SELECT_BIT1,
                 I_ADDR_SELECT_BIT0, I_SDA, I_SCL};

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_st = st;
    // Pins count once the second and third stage agree
    next_st.p1 = pins;
    next_st.p2 = st.p1;
    next_st.p3 = st.p2;
    nf = (st.p2 & st.p3) | (st.pf & (st.p2 ^ st.p3));
    next_st.pf = nf;
    scl_rise = nf[PIN_SCL] && !st.pf[PIN_SCL];
    scl_fall = !nf[PIN_SCL] && st.pf[PIN_SCL];
    start = nf[PIN_SCL] && st.pf[PIN_SCL]
      && !nf[PIN_SDA] && st.pf[PIN_SDA];
    stop = nf[PIN_SCL] && st.pf[PIN_SCL]
      && nf[PIN_SDA] && !st.pf[PIN_SDA];
    match = (st.sh[7:1] == {ADDR_FIXED, st.pf[PIN_SEL +: 3]});
    rd_next = ((st.ptr + 8'h01) == CTRL_REG_ADDR) ? st.ctrl : UNMAPPED_READ;

    // Sample toggle from the bit clock domain, same agree rule
    next_st.t1 = link.toggle;
    next_st.t2 = st.t1;
    next_st.t3 = st.t2;
    ntf = (st.t2 == st.t3) ? st.t3 : st.tf;
    next_st.tf = ntf;
    next_st.valid = (ntf != st.tf);
    if (ntf != st.tf)
    begin
      // Words stand still for a whole frame after the toggle
      next_st.left = link.left;
      next_st.right = link.right;
    end

    ////////////////////////////////////////////////////////////////////////

    if (start)
    begin
      // Repeated start also lands here; pointer is kept for reads
      next_st.state = ST_ADDR;
      next_st.cnt = 3'h0;
      next_st.got = 1'b0;
      next_st.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      next_st.state = ST_IDLE;
      next_st.got = 1'b0;
      next_st.sda_oe = 1'b0;
    end
    else
    begin
      case (st.state)
        ST_ADDR, ST_REG, ST_WDATA:
        begin
          if (scl_rise)
          begin
            next_st.sh = {st.sh[6:0], nf[PIN_SDA]};
            next_st.cnt = st.cnt + 3'h1;
            if (st.cnt == 3'h7)
              next_st.got = 1'b1;
          end
          else if (scl_fall && st.got)
          begin
            next_st.got = 1'b0;
            next_st.sda_oe = 1'b1;
            next_st.state = ST_ACK;
            next_st.ack_next = ST_WDATA;
            if (st.state == ST_ADDR)
            begin
              if (!match)
              begin
                next_st.sda_oe = 1'b0;
                next_st.state = ST_IGNORE;
              end
              else if (st.sh[0])
              begin
                next_st.ack_next = ST_RDATA;
                next_st.tx = (st.ptr == CTRL_REG_ADDR) ? st.ctrl
                  : UNMAPPED_READ;
              end
              else
                next_st.ack_next = ST_REG;
            end
            else if (st.state == ST_REG)
              next_st.ptr = st.sh;
            else
            begin
              if (st.ptr == CTRL_REG_ADDR)
                next_st.ctrl = st.sh;
              next_st.ptr = st.ptr + 8'h01;
            end
          end
        end
        ST_ACK:
        begin
          // Release only on the falling edge after the ack clock
          if (scl_fall)
          begin
            next_st.sda_oe = 1'b0;
            next_st.state = st.ack_next;
            if (st.ack_next == ST_RDATA)
            begin
              next_st.sda_oe = !st.tx[7];
              next_st.tx = {st.tx[6:0], 1'b0};
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_rise)
          begin
            next_st.cnt = st.cnt + 3'h1;
            if (st.cnt == 3'h7)
              next_st.got = 1'b1;
          end
          else if (scl_fall)
          begin
            if (st.got)
            begin
              next_st.got = 1'b0;
              next_st.sda_oe = 1'b0;
              next_st.state = ST_RACK;
            end
            else
            begin
              next_st.sda_oe = !st.tx[7];
              next_st.tx = {st.tx[6:0], 1'b0};
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            if (!nf[PIN_SDA])
            begin
              next_st.ptr = st.ptr + 8'h01;
              next_st.tx = rd_next;
              next_st.state = ST_RDATA;
            end
            else
              next_st.state = ST_IGNORE;
          end
        end
        ST_IDLE, ST_IGNORE:
        begin
          next_st.got = 1'b0;
        end
        default:
        begin
          next_st.state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      st <= '0;
      // Idle bus level in every stage: no false edge after release
      st.p1 <= PINS_IDLE;
      st.p2 <= PINS_IDLE;
      st.p3 <= PINS_IDLE;
      st.pf <= PINS_IDLE;
      st.ctrl <= CTRL_RESET;
    end
    else
      st <= next_st;
  end

  // Open drain: the pin level is only ever pulled low
  assign O_SDA = st.sda_out;
  assign O_SDA_OE = st.sda_oe;
  assign O_LEFT = st.left;
  assign O_RIGHT = st.right;
  assign O_SAMPLE_VALID = st.valid;
  assign O_FORMAT = st.ctrl[FMT_LSB +: 2];
  assign O_MUTE = st.ctrl[MUTE_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  sequence addr_byte_s;
    st.state == ST_ADDR && st.got && scl_fall && !start && !stop;
  endsequence

  sequence ack_drive_s;
    st.state == ST_ACK && st.sda_oe && !O_SDA;
  endsequence

  ack_on_match_a: assert property (addr_byte_s ##0 match
    |=> ack_drive_s)
    else $error("matching address not acknowledged");
  no_match_a: assert property (addr_byte_s ##0 !match
    |=> st.state == ST_IGNORE && !st.sda_oe)
    else $error("foreign address was acknowledged");
  ack_whole_a: assert property (ack_drive_s ##0 !scl_fall
    && !start && !stop |=> ack_drive_s)
    else $error("acknowledge released early");
  direction_a: assert property (addr_byte_s ##0 match
    |=> st.ack_next == ($past(st.sh[0]) ? ST_RDATA : ST_REG))
    else $error("direction bit misread");
  start_seen_a: assert property (start
    |=> st.state == ST_ADDR && st.cnt == 3'h0 && !st.sda_oe)
    else $error("start not taken");
  stop_seen_a: assert property (stop
    |=> st.state == ST_IDLE && !st.sda_oe)
    else $error("stop not taken");
  drive_low_a: assert property ($changed(st.sda_oe)
    && !$past(start) && !$past(stop) |-> !st.pf[PIN_SCL])
    else $error("data line moved while clock high");
  msb_first_a: assert property (st.state == ST_ADDR && scl_rise
    && !start && !stop ##1 st.state == ST_ADDR
    |-> st.sh == {$past(st.sh[6:0]), $past(nf[PIN_SDA])})
    else $error("bus bit not shifted in MSB first");
  ctrl_write_a: assert property (st.state == ST_WDATA && st.got
    && scl_fall && st.ptr == CTRL_REG_ADDR && !start && !stop
    |=> st.ctrl == $past(st.sh) && O_FORMAT == $past(st.sh[1:0]))
    else $error("control byte not written");
  ptr_step_a: assert property (st.state == ST_WDATA && st.got
    && scl_fall && !start && !stop
    |=> st.ptr == $past(st.ptr) + 8'h01 ##0 ack_drive_s)
    else $error("register pointer did not advance");
  frame_valid_a: assert property (st.tf != $past(st.tf)
    |-> st.valid ##1 !st.valid)
    else $error("frame not flagged exactly once");
  rack_release_a: assert property (st.state == ST_RDATA && st.got
    && scl_fall && !start && !stop |=> st.state == ST_RACK && !st.sda_oe)
    else $error("line not released for controller acknowledge");
  read_msb_a: assert property (st.state == ST_RDATA && !st.got
    && scl_fall && !start && !stop |=> st.sda_oe == !$past(st.tx[7]))
    else $error("read bit not driven MSB first");

endmodule

// *** hdl/rx_link_if.sv ***
// Purpose: Carries format and finished samples between the two domains
// Assumes: Samples stand still between toggles of the toggle line
// Notes: Format crosses into the bit clock domain, samples cross back
`timescale 1ns/1ps
interface rx_link_if
  import adly_pkg::*;
  ;
  logic [1:0] fmt;
  logic [SAMPLE_W-1:0] left;
  logic [SAMPLE_W-1:0] right;
  logic toggle;

  modport ctrl (output fmt, input left, input right, input toggle);
  modport rx (input fmt, output left, output right, output toggle);
endinterface

// *** hdl/serial_audio_rx.sv ***
// Purpose: Serial audio receiver running on the bit clock
// Assumes: Word clock and data are synchronous to the bit clock
// Notes: Right-justified words keep only the last SAMPLE_W bits
`timescale 1ns/1ps
module serial_audio_rx
  import adly_pkg::*;
(
  // Link clock and reset
  input wire logic i_bclk,
  input wire logic i_rst,
  // Serial audio pins
  input wire logic i_lrclk,
  input wire logic i_data,
  // Toward the control side
  rx_link_if.rx link
);

  typedef struct packed {
    logic [1:0] fs1;
    logic [1:0] fs2;
    logic [1:0] fs3;
    logic [1:0] fmt;
    logic lr_prev;
    logic [5:0] cnt;
    logic [SAMPLE_W-1:0] cap;
    logic [SAMPLE_W-1:0] sh;
    logic [SAMPLE_W-1:0] left_hold;
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
    logic toggle;
  } rx_state_t;

  rx_state_t st;
  rx_state_t next_st;
  logic change;
  logic i2s_mode;
  logic left_slot;
  logic fin_app;
  logic [5:0] fin_cnt;
  logic [SAMPLE_W-1:0] fin_cap;
  logic [SAMPLE_W-1:0] word;

  always_comb
  begin
    next_st = st;
    // Format changes count once two late stages agree
    next_st.fs1 = link.fmt;
    next_st.fs2 = st.fs1;
    next_st.fs3 = st.fs2;
    if (st.fs2 == st.fs3)
      next_st.fmt = st.fs3;
    // Bypass keeps I2S framing on the input
    i2s_mode = (st.fmt == FMT_I2S) || (st.fmt == FMT_BYPASS);
    change = (i_lrclk != st.lr_prev);
    // I2S: the bit at the word clock edge is the old word's LSB
    fin_app = i2s_mode && (st.cnt < 6'(SAMPLE_W));
    fin_cap = fin_app ? {st.cap[SAMPLE_W-2:0], i_data} : st.cap;
    fin_cnt = fin_app ? st.cnt + 6'h01 : st.cnt;
    if (fin_cnt >= 6'(SAMPLE_W))
      word = fin_cap;
    else
      word = fin_cap << (6'(SAMPLE_W) - fin_cnt);
    if (st.fmt == FMT_RJ)
      word = st.sh;
    left_slot = i2s_mode ? !st.lr_prev : st.lr_prev;
    next_st.lr_prev = i_lrclk;
    next_st.sh = {st.sh[SAMPLE_W-2:0], i_data};
    if (change)
    begin
      if (left_slot)
        next_st.left_hold = word;
      else
      begin
        // One hand-over per word clock period
        next_st.left = st.left_hold;
        next_st.right = word;
        next_st.toggle = !st.toggle;
      end
      if (i2s_mode)
      begin
        next_st.cap = '0;
        next_st.cnt = 6'h00;
      end
      else
      begin
        next_st.cap = {{(SAMPLE_W-1){1'b0}}, i_data};
        next_st.cnt = 6'h01;
      end
    end
    else
    begin
      if (st.cnt < 6'(SAMPLE_W))
        next_st.cap = {st.cap[SAMPLE_W-2:0], i_data};
      // Saturation keeps 64 clocks per slot safe
      if (st.cnt != 6'h3f)
        next_st.cnt = st.cnt + 6'h01;
    end
  end

  // All audio timing runs on the incoming bit clock
  always_ff @(posedge i_bclk or posedge i_rst)
  begin
    if (i_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign link.left = st.left;
  assign link.right = st.right;
  assign link.toggle = st.toggle;

  sample_rise_a: assert property (@(posedge i_bclk) disable iff (i_rst)
    1'b1 |=> st.sh[0] == $past(i_data))
    else $error("data bit not shifted on bit clock rise");
  frame_handover_a: assert property (@(posedge i_bclk) disable iff (i_rst)
    change && !left_slot |=> st.toggle != $past(st.toggle)
      && st.right == $past(word))
    else $error("right slot end did not hand over a frame");
  i2s_left_a: assert property (@(posedge i_bclk) disable iff (i_rst)
    st.fmt == FMT_I2S && change && !st.lr_prev
      |=> st.left_hold == $past(word) && st.toggle == $past(st.toggle))
    else $error("I2S low slot not taken as left");
  lj_left_a: assert property (@(posedge i_bclk) disable iff (i_rst)
    st.fmt == FMT_LJ && change && st.lr_prev
      |=> st.left_hold == $past(word) && st.toggle == $past(st.toggle))
    else $error("justified high slot not taken as left");

endmodule
